// *** hdl/mld_decoder.sv ***
// Purpose: Decode and execute the counter, immediate and jump load group
// Assumes: Instruction, ALU operands and Data RAM read data are on aclk
// Notes:   Combinational Data RAM read; one-cycle loads
`timescale 1ns/100ps

// Function
// - ALU counter load copies source, applies shortcuts
// - Clear flag zeroes counter, else keep
// - Action 00 keep 01 off 10 on 11 invert
// - Select 00..11 picks limit one..four
// - ALU counter load opcode layout 101...100
// - Source field names an ALU operand register
// - RAM counter load from 6-bit address
// - Index flag adds address base
// - RAM counter load opcode layout 01...
// - Shortcuts act through predefined output mapping
// - Upper immediate byte load, clear zeroes
// - Upper immediate opcode 00111 ... 11
// - Lower immediate byte load, clear zeroes
// - Lower immediate opcode 00111 ... 10
// - First jump load writes jump value
// - First jump opcode 1000 ... 00
// - Second jump load writes jump value
// - Second jump opcode 1001 ... 00
// - Jump targets feed far jump and call
module mld_decoder
   import mld_pkg::*;
#(
   parameter int NUM_OUTPUTS = 8,
   parameter int MAP_W       = 3,
   parameter int DRAM_AW     = 6,
   parameter int NUM_ALU     = 8
) (
   input  wire logic                    aclk,
   input  wire logic                    aresetn,
   // Instruction issue
   input  wire logic                    instr_valid,
   input  wire logic [15:0]             instr_word,
   output logic                         load_executed,
   // ALU operand set, register k in bits 16k+15:16k
   input  wire logic [16*NUM_ALU-1:0]   alu_operand_set,
   // Data RAM read port and address base
   output logic      [DRAM_AW-1:0]      dram_addr,
   output logic                         dram_rd_en,
   input  wire logic [15:0]             dram_rdata,
   input  wire logic [DRAM_AW-1:0]      address_base,
   // Shortcut mapping from the definition logic
   input  wire logic [MAP_W-1:0]        shortcut_first_map,
   input  wire logic [MAP_W-1:0]        shortcut_second_map,
   // Results
   output logic      [NUM_OUTPUTS-1:0]  output_enable_state,
   output logic      [63:0]             count_limits,
   output logic      [3:0]              count_limit_load,
   output logic      [3:0]              counter_clear,
   output logic      [15:0]             immediate_value_reg,
   output logic      [15:0]             jump_target_one,
   output logic      [15:0]             jump_target_two,
   // AXI4-Lite slave
   input  wire logic [7:0]              s_axi_awaddr,
   input  wire logic                    s_axi_awvalid,
   output logic                         s_axi_awready,
   input  wire logic [31:0]             s_axi_wdata,
   input  wire logic [3:0]              s_axi_wstrb,
   input  wire logic                    s_axi_wvalid,
   output logic                         s_axi_wready,
   output logic      [1:0]              s_axi_bresp,
   output logic                         s_axi_bvalid,
   input  wire logic                    s_axi_bready,
   input  wire logic [7:0]              s_axi_araddr,
   input  wire logic                    s_axi_arvalid,
   output logic                         s_axi_arready,
   output logic      [31:0]             s_axi_rdata,
   output logic      [1:0]              s_axi_rresp,
   output logic                         s_axi_rvalid,
   input  wire logic                    s_axi_rready
);

   ////////////////////////////////////////////////////////////////////////////
   // Functions

   // Opcode match under a mask
   function automatic logic op_match(input logic [15:0] w, input logic [15:0] m,
                                     input logic [15:0] v);
      op_match = (w & m) == v;
   endfunction : op_match

   // One-hot of a two-bit limit select
   function automatic logic [3:0] sel_onehot(input logic [1:0] sel);
      sel_onehot = 4'(4'h1 << sel);
   endfunction : sel_onehot

   // Register map decode, shared by read and write paths
   function automatic logic addr_mapped(input logic [7:0] a);
      addr_mapped = (a == OFS_CTRL) || (a == OFS_IMMEDIATE) || (a == OFS_JUMP) ||
                    (a == OFS_OUTPUTS) || (a == OFS_LIMIT01) ||
                    (a == OFS_LIMIT23) || (a == OFS_EXEC_CNT);
   endfunction : addr_mapped

   ////////////////////////////////////////////////////////////////////////////
   // State

   logic                   exec_enable;     // Software gate for execution
   logic [15:0]            exec_count;      // Executed load counter
   logic [15:0]            limit_reg [4];   // Count limits one to four
   logic                   aw_held;
   logic                   w_held;
   logic [7:0]             aw_addr;
   logic [31:0]            w_data;
   logic [3:0]             w_strb;

   ////////////////////////////////////////////////////////////////////////////
   // Instruction decode

   wire logic go = instr_valid && exec_enable;

   wire logic is_load_alu = go && op_match(instr_word, LDCA_MASK, LDCA_MATCH);
   wire logic is_load_ram = go && op_match(instr_word, LDCD_MASK, LDCD_MATCH);
   wire logic is_imm_high = go && op_match(instr_word, LDIR_MASK, LDIRH_MATCH);
   wire logic is_imm_low  = go && op_match(instr_word, LDIR_MASK, LDIRL_MATCH);
   wire logic is_jump_one = go && op_match(instr_word, LDJR_MASK, LOAD_JUMP_TARGET_ONE_MATCH);
   wire logic is_jump_two = go && op_match(instr_word, LDJR_MASK, LOAD_JUMP_TARGET_TWO_MATCH);

   wire logic is_count_load = is_load_alu || is_load_ram;
   wire logic any_load      = is_count_load || is_imm_high || is_imm_low ||
                              is_jump_one || is_jump_two;

   // Field extraction
   wire logic [1:0] shortcut_first_action  = instr_word[SHORT_FIRST_LSB +: 2];
   wire logic [1:0] shortcut_second_action = instr_word[SHORT_SECOND_LSB +: 2];
   wire logic [1:0] limit_sel              = instr_word[LIMIT_SEL_LSB +: 2];
   wire logic       count_clear_flag       = instr_word[CLR_FLAG_BIT];
   wire logic       indexed_mode           = instr_word[RAM_INDEX_BIT];
   wire logic [2:0] source_operand         = instr_word[ALU_SRC_LSB +: 3];
   wire logic [5:0] ram_field              = instr_word[RAM_ADDR_LSB +: 6];
   wire logic       upper_clear_flag       = instr_word[IMM_CLR_BIT];
   wire logic       lower_clear_flag       = instr_word[IMM_CLR_BIT];
   wire logic [7:0] byte_value             = instr_word[BYTE_VALUE_LSB +: 8];
   wire logic [9:0] jump_value             = instr_word[JUMP_VALUE_LSB +: 10];

   // ALU source picks one operand register
   wire logic [15:0] alu_source = alu_operand_set[16*source_operand +: 16];

   wire logic [DRAM_AW-1:0] ram_direct = DRAM_AW'(ram_field);
   wire logic [DRAM_AW-1:0] ram_sum    = DRAM_AW'(ram_direct + address_base);
   assign dram_addr  = indexed_mode ? ram_sum : ram_direct;
   assign dram_rd_en = is_load_ram;

   // Limit value from ALU or Data RAM
   wire logic [15:0] limit_value = is_load_alu ? alu_source : dram_rdata;
   wire logic [3:0]  limit_hit   = is_count_load ? sel_onehot(limit_sel) : 4'h0;

   ////////////////////////////////////////////////////////////////////////////
   // Shortcut outputs

   logic [NUM_OUTPUTS-1:0] after_first;
   logic [NUM_OUTPUTS-1:0] after_second;

   mld_shortcut_apply #(
      .NUM_OUTPUTS (NUM_OUTPUTS),
      .MAP_W       (MAP_W)
   ) u_short_first (
      .state_in  (output_enable_state),
      .target    (shortcut_first_map),
      .action    (shortcut_first_action),
      .state_out (after_first)
   );

   // Second shortcut applied after the first
   mld_shortcut_apply #(
      .NUM_OUTPUTS (NUM_OUTPUTS),
      .MAP_W       (MAP_W)
   ) u_short_second (
      .state_in  (after_first),
      .target    (shortcut_second_map),
      .action    (shortcut_second_action),
      .state_out (after_second)
   );

   // Commit shortcut actions on counter loads
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         output_enable_state <= '0;
      end else if (is_count_load) begin
         output_enable_state <= after_second;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Count limits and counter clear

   // Limit written in the decode cycle
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         for (int i = 0; i < 4; i++) begin
            limit_reg[i] <= RST_WORD16;
         end
      end else begin
         for (int i = 0; i < 4; i++) begin
            if (limit_hit[i]) begin
               limit_reg[i] <= limit_value;
            end
         end
      end
   end

   // Clear pulse only when the flag is set
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         count_limit_load <= 4'h0;
         counter_clear    <= 4'h0;
      end else begin
         count_limit_load <= limit_hit;
         counter_clear    <= count_clear_flag ? limit_hit : 4'h0;
      end
   end

   assign count_limits = {limit_reg[3], limit_reg[2], limit_reg[1], limit_reg[0]};

   ////////////////////////////////////////////////////////////////////////////
   // Immediate register

   // Upper byte: value, or zero when cleared
   wire logic [7:0] next_imm_high = upper_clear_flag ? 8'h00 : byte_value;
   // Lower byte: value, or zero when cleared
   wire logic [7:0] next_imm_low  = lower_clear_flag ? 8'h00 : byte_value;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         immediate_value_reg <= RST_WORD16;
      end else if (is_imm_high) begin
         immediate_value_reg[15:8] <= next_imm_high;
      end else if (is_imm_low) begin
         immediate_value_reg[7:0] <= next_imm_low;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Jump targets

   wire logic [15:0] jump_wide = {6'h00, jump_value};

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         jump_target_one <= RST_WORD16;
         jump_target_two <= RST_WORD16;
      end else begin
         if (is_jump_one) begin
            jump_target_one <= jump_wide;
         end
         if (is_jump_two) begin
            jump_target_two <= jump_wide;
         end
      end
   end

   // Executed pulse and running count
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         load_executed <= 1'b0;
         exec_count    <= RST_EXEC_CNT;
      end else begin
         load_executed <= any_load;
         if (any_load) begin
            exec_count <= exec_count + 16'h0001;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // AXI4-Lite write path

   assign s_axi_awready = !aw_held && !s_axi_bvalid;
   assign s_axi_wready  = !w_held && !s_axi_bvalid;

   wire logic aw_take  = s_axi_awvalid && s_axi_awready;
   wire logic w_take   = s_axi_wvalid && s_axi_wready;
   wire logic wr_fire  = aw_held && w_held && !s_axi_bvalid;
   wire logic wr_ctrl  = wr_fire && (aw_addr == OFS_CTRL) && w_strb[0];

   // Hold address and data until both are in
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held <= 1'b0;
         w_held  <= 1'b0;
         aw_addr <= 8'h00;
         w_data  <= 32'h0000_0000;
         w_strb  <= 4'h0;
      end else begin
         if (aw_take) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end else if (wr_fire) begin
            aw_held <= 1'b0;
         end
         if (w_take) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end else if (wr_fire) begin
            w_held <= 1'b0;
         end
      end
   end

   // Response and control register
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= RESP_OKAY;
         exec_enable  <= RST_ENABLE;
      end else begin
         if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= addr_mapped(aw_addr) ? RESP_OKAY : RESP_DECERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
         if (wr_ctrl) begin
            exec_enable <= w_data[0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // AXI4-Lite read path

   assign s_axi_arready = !s_axi_rvalid;

   logic [31:0] rd_mux;

   // Read data select
   always_comb begin
      rd_mux = 32'h0000_0000;
      unique case (s_axi_araddr)
         OFS_CTRL:      rd_mux = {31'h0, exec_enable};
         OFS_IMMEDIATE: rd_mux = {16'h0000, immediate_value_reg};
         OFS_JUMP:      rd_mux = {jump_target_two, jump_target_one};
         OFS_OUTPUTS:   rd_mux = 32'(output_enable_state);
         OFS_LIMIT01:   rd_mux = {limit_reg[1], limit_reg[0]};
         OFS_LIMIT23:   rd_mux = {limit_reg[3], limit_reg[2]};
         OFS_EXEC_CNT:  rd_mux = {16'h0000, exec_count};
         default:       rd_mux = 32'h0000_0000;
      endcase
   end

   // Registered read answer
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= rd_mux;
         s_axi_rresp  <= addr_mapped(s_axi_araddr) ? RESP_OKAY : RESP_DECERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

endmodule : mld_decoder

// *** hdl/mld_pkg.sv ***
// Purpose: Shared constants for the microcore load-instruction decoder
// Assumes: 16-bit instruction words, 32-bit AXI4-Lite register access
// Notes:   Opcodes as mask and match pairs
package mld_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Instruction field positions
   localparam int CLR_FLAG_BIT      = 12;  // Counter clear flag
   localparam int RAM_INDEX_BIT     = 13;  // Indexed mode select
   localparam int SHORT_FIRST_LSB   = 10;  // First shortcut action, bits 11:10
   localparam int SHORT_SECOND_LSB  = 8;   // Second shortcut action, bits 9:8
   localparam int LIMIT_SEL_LSB     = 6;   // Count-limit select, bits 7:6
   localparam int ALU_SRC_LSB       = 3;   // ALU source, bits 5:3
   localparam int RAM_ADDR_LSB      = 0;   // Data RAM address, bits 5:0
   localparam int IMM_CLR_BIT       = 10;  // Byte clear flag, immediate loads
   localparam int BYTE_VALUE_LSB    = 2;   // Byte value, bits 9:2
   localparam int JUMP_VALUE_LSB    = 2;   // Jump value, bits 11:2

   ////////////////////////////////////////////////////////////////////////////
   // Opcode mask and match values
   localparam logic [15:0] LDCA_MASK  = 16'hE007;
   localparam logic [15:0] LDCA_MATCH = 16'hA004;
   localparam logic [15:0] LDCD_MASK  = 16'hC000;
   localparam logic [15:0] LDCD_MATCH = 16'h4000;
   localparam logic [15:0] LDIR_MASK  = 16'hF803;
   localparam logic [15:0] LDIRH_MATCH = 16'h3803;
   localparam logic [15:0] LDIRL_MATCH = 16'h3802;
   localparam logic [15:0] LDJR_MASK  = 16'hF003;
   localparam logic [15:0] LOAD_JUMP_TARGET_ONE_MATCH = 16'h8000;
   localparam logic [15:0] LOAD_JUMP_TARGET_TWO_MATCH = 16'h9000;

   ////////////////////////////////////////////////////////////////////////////
   // Shortcut action codes
   localparam logic [1:0] ACT_KEEP   = 2'h0;
   localparam logic [1:0] ACT_OFF    = 2'h1;
   localparam logic [1:0] ACT_ON     = 2'h2;
   localparam logic [1:0] ACT_TOGGLE = 2'h3;

   ////////////////////////////////////////////////////////////////////////////
   // Register byte offsets
   localparam logic [7:0] OFS_CTRL      = 8'h00;
   localparam logic [7:0] OFS_IMMEDIATE = 8'h04;
   localparam logic [7:0] OFS_JUMP      = 8'h08;
   localparam logic [7:0] OFS_OUTPUTS   = 8'h0C;
   localparam logic [7:0] OFS_LIMIT01   = 8'h10;
   localparam logic [7:0] OFS_LIMIT23   = 8'h14;
   localparam logic [7:0] OFS_EXEC_CNT  = 8'h18;

   // Reset values
   localparam logic        RST_ENABLE   = 1'b1;
   localparam logic [15:0] RST_WORD16   = 16'h0000;
   localparam logic [15:0] RST_EXEC_CNT = 16'h0000;

   // AXI responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_DECERR = 2'h3;

endpackage : mld_pkg

// *** hdl/mld_shortcut_apply.sv ***
// Purpose: Applies one shortcut action to one bit of an output vector
// Assumes: Mapping index comes from the shortcut definition logic
// Notes:   Combinational, one per shortcut
`timescale 1ns/100ps
module mld_shortcut_apply
   import mld_pkg::*;
#(
   parameter int NUM_OUTPUTS = 8,
   parameter int MAP_W       = 3
) (
   input  wire logic [NUM_OUTPUTS-1:0] state_in,
   input  wire logic [MAP_W-1:0]       target,
   input  wire logic [1:0]             action,
   output logic      [NUM_OUTPUTS-1:0] state_out
);

   // One-hot of the mapped output
   wire logic [NUM_OUTPUTS-1:0] hit = NUM_OUTPUTS'(1) << target;

   // Per-bit action: keep, off, on, invert
   always_comb begin
      state_out = state_in;
      unique case (action)
         ACT_KEEP:   state_out = state_in;
         ACT_OFF:    state_out = state_in & ~hit;
         ACT_ON:     state_out = state_in | hit;
         ACT_TOGGLE: state_out = state_in ^ hit;
      endcase
   end

endmodule : mld_shortcut_apply

// *** dv/mld_checker.sv ***
// Purpose: Load decoder assertions
// Assumes: One clock, sync active-low reset
// Notes:   Bind at file end
`timescale 1ns/100ps
module mld_checker
   import mld_pkg::*;
#(
   parameter int DRAM_AW = 6,
   parameter int NUM_ALU = 8
) (
   input wire logic                 aclk,
   input wire logic                 aresetn,
   input wire logic                 instr_valid,
   input wire logic [15:0]          instr_word,
   input wire logic                 load_executed,
   input wire logic [16*NUM_ALU-1:0] alu_operand_set,
   input wire logic [DRAM_AW-1:0]   dram_addr,
   input wire logic                 dram_rd_en,
   input wire logic [15:0]          dram_rdata,
   input wire logic [DRAM_AW-1:0]   address_base,
   input wire logic [63:0]          count_limits,
   input wire logic [3:0]           count_limit_load,
   input wire logic [3:0]           counter_clear,
   input wire logic [15:0]          immediate_value_reg,
   input wire logic [15:0]          jump_target_one,
   input wire logic [15:0]          jump_target_two
);
   ////////////////////////////////
   // Opcode matches
   wire is_ca = instr_valid && ((instr_word & 16'hE007) == 16'hA004);
   wire is_cd = instr_valid && ((instr_word & 16'hC000) == 16'h4000);
   wire is_ih = instr_valid && ((instr_word & 16'hF803) == 16'h3803);
   wire is_il = instr_valid && ((instr_word & 16'hF803) == 16'h3802);
   wire is_j1 = instr_valid && ((instr_word & 16'hF003) == 16'h8000);
   wire is_j2 = instr_valid && ((instr_word & 16'hF003) == 16'h9000);
   wire any_m = is_ca || is_cd || is_ih || is_il || is_j1 || is_j2;
   logic [15:0] q_w;
   logic [15:0] q_alu;
   logic [15:0] q_ram;
   // Decoded word and its sources
   always_ff @(posedge aclk) begin
      q_w   <= instr_word;
      q_alu <= alu_operand_set[16*instr_word[5:3] +: 16];
      q_ram <= dram_rdata;
   end
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   ////////////////////////////////
   // Load then completion
   sequence s_ca; is_ca ##1 load_executed; endsequence
   sequence s_cd; is_cd ##1 load_executed; endsequence
   sequence s_cnt; (is_ca || is_cd) ##1 load_executed; endsequence
   sequence s_ih; is_ih ##1 load_executed; endsequence
   sequence s_il; is_il ##1 load_executed; endsequence
   property p_ca_val; s_ca |-> count_limits[16*q_w[7:6] +: 16] == q_alu; endproperty
   property p_cd_val; s_cd |-> count_limits[16*q_w[7:6] +: 16] == q_ram; endproperty
   property p_sel; s_cnt |-> count_limit_load == 4'h1 << q_w[7:6]; endproperty
   property p_clr; s_cnt |-> counter_clear == (q_w[12] ? count_limit_load : 4'h0); endproperty
   property p_addr;
      is_cd |-> dram_rd_en && dram_addr ==
         (instr_word[13] ? instr_word[DRAM_AW-1:0] + address_base : instr_word[DRAM_AW-1:0]);
   endproperty
   property p_ih;
      s_ih |-> immediate_value_reg[15:8] == (q_w[10] ? 8'h00 : q_w[9:2])
         && $stable(immediate_value_reg[7:0]);
   endproperty
   property p_il;
      s_il |-> immediate_value_reg[7:0] == (q_w[10] ? 8'h00 : q_w[9:2])
         && $stable(immediate_value_reg[15:8]);
   endproperty
   property p_j1; is_j1 ##1 load_executed |-> jump_target_one == {6'h00, q_w[11:2]}; endproperty
   property p_j2; is_j2 ##1 load_executed |-> jump_target_two == {6'h00, q_w[11:2]}; endproperty
   property p_refuse; !any_m |=> !load_executed; endproperty
   a_ca_val: assert property (p_ca_val) else $error("alu limit wrong");
   a_cd_val: assert property (p_cd_val) else $error("ram limit wrong");
   a_sel: assert property (p_sel) else $error("wrong limit selected");
   a_clr: assert property (p_clr) else $error("clear wrong");
   a_addr: assert property (p_addr) else $error("ram addr wrong");
   a_ih: assert property (p_ih) else $error("imm high wrong");
   a_il: assert property (p_il) else $error("imm low wrong");
   a_j1: assert property (p_j1) else $error("jump one wrong");
   a_j2: assert property (p_j2) else $error("jump two wrong");
   a_refuse: assert property (p_refuse) else $error("stray load");
endmodule : mld_checker

bind mld_decoder mld_checker #(.DRAM_AW(DRAM_AW), .NUM_ALU(NUM_ALU)) u_mld_checker (
   .aclk, .aresetn, .instr_valid, .instr_word, .load_executed, .alu_operand_set,
   .dram_addr, .dram_rd_en, .dram_rdata, .address_base, .count_limits,
   .count_limit_load, .counter_clear, .immediate_value_reg, .jump_target_one,
   .jump_target_two);

// *** dv/mld_decoder_tb.sv ***
// Purpose: Load decoder bench
// Assumes: Default parameters
// Notes:   Bench plays Data RAM and bus master
`timescale 1ns/100ps
module mld_decoder_tb
   import mld_pkg::*;
;
   logic aclk = 1'h0, aresetn = 1'h0, instr_valid = 1'h0, load_executed, dram_rd_en;
   logic [15:0] instr_word = 16'h0000, dram_rdata, immediate_value_reg;
   logic [15:0] jump_target_one, jump_target_two;
   logic [127:0] alu_operand_set;
   logic [5:0] dram_addr, address_base = 6'h05;
   logic [2:0] shortcut_first_map = 3'h2, shortcut_second_map = 3'h5;
   logic [7:0] output_enable_state, s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, oe = 8'h00;
   logic [63:0] count_limits;
   logic [3:0] count_limit_load, counter_clear, s_axi_wstrb = 4'hF;
   logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata;
   logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
   logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   int n_errors = 0, compares = 0, n_exec = 0;

   always #12.5 aclk = ~aclk;
   // Async-read Data RAM
   assign dram_rdata = {10'h155, dram_addr};

   mld_decoder u_mld_decoder (
      .aclk, .aresetn, .instr_valid, .instr_word, .load_executed, .alu_operand_set,
      .dram_addr, .dram_rd_en, .dram_rdata, .address_base, .shortcut_first_map,
      .shortcut_second_map, .output_enable_state, .count_limits, .count_limit_load,
      .counter_clear, .immediate_value_reg, .jump_target_one, .jump_target_two,
      .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready);

   ////////////////////////////////
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   task automatic wrap_up;
      $display("Compares %0d mismatches %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : wrap_up

   // One instruction, checked next cycle
   task automatic issue(input logic [15:0] w, input logic ex);
      @(posedge aclk);
      instr_valid <= 1'h1;
      instr_word  <= w;
      @(posedge aclk);
      instr_valid <= 1'h0;
      #1;
      n_exec += ex;
      chk("executed", load_executed, ex);
   endtask : issue

   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      logic ta, tw, got;
      @(posedge aclk);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid  <= 1'h1;
      s_axi_bready  <= 1'h1;
      do begin
         #1;
         ta = s_axi_awvalid && s_axi_awready;
         tw = s_axi_wvalid && s_axi_wready;
         @(posedge aclk);
         if (ta) s_axi_awvalid <= 1'h0;
         if (tw) s_axi_wvalid <= 1'h0;
      end while ((s_axi_awvalid && !ta) || (s_axi_wvalid && !tw));
      do begin
         #1;
         got = s_axi_bvalid;
         r = s_axi_bresp;
         @(posedge aclk);
      end while (!got);
      s_axi_bready <= 1'h0;
   endtask : axi_wr

   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      logic got;
      @(posedge aclk);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready  <= 1'h1;
      do begin
         #1;
         got = s_axi_arready;
         @(posedge aclk);
      end while (!got);
      s_axi_arvalid <= 1'h0;
      do begin
         #1;
         got = s_axi_rvalid;
         d = s_axi_rdata;
         r = s_axi_rresp;
         @(posedge aclk);
      end while (!got);
      s_axi_rready <= 1'h0;
   endtask : axi_rd

   // Expected shortcut effect
   function automatic logic [7:0] sc(input logic [7:0] s, input logic [2:0] t,
                                     input logic [1:0] a);
      if (a == 2'h1) s[t] = 1'h0;
      if (a == 2'h2) s[t] = 1'h1;
      if (a == 2'h3) s[t] = ~s[t];
      return s;
   endfunction : sc

   ////////////////////////////////
   initial begin
      logic [31:0] d;
      logic [1:0]  r;
      logic [15:0] w;
      for (int k = 0; k < 8; k++) alu_operand_set[16*k +: 16] = 16'hA000 + 16'(k);
      repeat (5) @(posedge aclk);
      aresetn <= 1'h1;
      axi_rd(OFS_CTRL, d, r);
      chk("ctrl reset", d, 32'h0000_0001);
      axi_rd(8'h40, d, r);
      chk("unmapped rd", {d[29:0], r}, {30'h0, RESP_DECERR});
      $display("Reset test done");
      issue({4'h8, 10'h3FF, 2'h0}, 1'h1);
      chk("jump one", jump_target_one, 16'h03FF);
      issue({4'h9, 10'h2AA, 2'h0}, 1'h1);
      chk("jump two", jump_target_two, 16'h02AA);
      axi_rd(OFS_JUMP, d, r);
      chk("jump reg", d, 32'h02AA_03FF);
      $display("Jump test done");
      issue({5'h07, 1'h0, 8'hA5, 2'h3}, 1'h1);
      chk("imm", immediate_value_reg, 16'hA500);
      issue({5'h07, 1'h0, 8'h3C, 2'h2}, 1'h1);
      chk("imm", immediate_value_reg, 16'hA53C);
      issue({5'h07, 1'h1, 8'hFF, 2'h3}, 1'h1);
      chk("imm", immediate_value_reg, 16'h003C);
      issue({5'h07, 1'h1, 8'hFF, 2'h2}, 1'h1);
      chk("imm", immediate_value_reg, 16'h0000);
      $display("Immediate test done");
      for (int i = 0; i < 10; i++) begin
         if (i < 8) w = {3'h5, 1'(i), 2'(i), 2'(i + 1), 2'(i), 3'(i), 3'h4};
         else w = {2'h1, 1'(i), 1'h1, 2'h2, 2'h3, 2'(i), 6'h3F};
         issue(w, 1'h1);
         oe = sc(sc(oe, shortcut_first_map, w[11:10]), shortcut_second_map, w[9:8]);
         if (i < 8) chk("limit", count_limits[16*w[7:6] +: 16], 16'hA000 + 16'(i));
         else chk("limit", count_limits[16*w[7:6] +: 16], {10'h155, i[0] ? 6'h04 : 6'h3F});
         chk("load", count_limit_load, 4'h1 << w[7:6]);
         chk("clear", counter_clear, w[12] ? 4'h1 << w[7:6] : 4'h0);
         chk("outputs", output_enable_state, oe);
      end
      $display("Counter test done");
      issue(16'h0000, 1'h0);
      axi_wr(OFS_CTRL, 32'h0000_0000, r);
      issue({4'h8, 10'h001, 2'h0}, 1'h0);
      chk("jump held", jump_target_one, 16'h03FF);
      axi_wr(8'h40, 32'h0000_0001, r);
      chk("unmapped wr", r, RESP_DECERR);
      axi_wr(OFS_CTRL, 32'h0000_0001, r);
      chk("ctrl wr", r, RESP_OKAY);
      @(posedge aclk);
      instr_valid <= 1'h1;
      instr_word  <= {4'h8, 10'h012, 2'h0};
      @(posedge aclk);
      instr_word  <= {4'h9, 10'h034, 2'h0};
      @(posedge aclk);
      instr_valid <= 1'h0;
      #1;
      n_exec += 2;
      chk("b2b", {jump_target_two, jump_target_one}, 32'h0034_0012);
      axi_rd(OFS_EXEC_CNT, d, r);
      chk("exec count", d, 32'(n_exec));
      $display("Refusal test done");
      wrap_up();
   end

   // Hang watchdog
   initial begin
      repeat (20000) @(posedge aclk);
      n_errors++;
      wrap_up();
   end
endmodule : mld_decoder_tb
